// ==== design/bcs_pkg.sv ====
// Package for the bus cycle status and strobe block: codes, ranges, carriers.
// What this block does
// - Drive three-bit active-low cycle status code per cycle type.
// - Float cycle status during bus hold and hold acknowledge.
// - DMA cycle flag high in phases two to four of DMA cycles.
// - Float DMA cycle flag during bus hold and reset.
// - Bus lock flag driven low only in first phase of cycle.
// - Synchronous ready high means ready; low defers to synchronised asynchronous ready.
// - Upper block select asserted for memory cycles in programmable upper range; high during hold.
// - After reset the upper block covers F0000h to FFFFFh.
// - Upper-zero indicator low when address bits 19 to 16 are zero.
// - Upper-zero indicator set in first phase, stable until cycle end.
// - High-lane strobe is OR of high byte enable and write strobe.
// - Low-lane strobe is OR of address bit zero and write strobe.
// - Eight-bit variant drives one early write byte strobe, floated in reset.
// - Write strobe asserted for writes, floated during hold or reset.
// - Address-enable strap low at reset release selects normal emulator pin functions.
// - Multiplexed lines carry address only in first phase; address lines whole cycle.
package bcs_pkg;
  typedef enum logic [2:0] {
    CYC_INTA = 3'h0, CYC_IORD = 3'h1, CYC_IOWR = 3'h2, CYC_HALT = 3'h3,
    CYC_FETCH = 3'h4, CYC_MEMRD = 3'h5, CYC_MEMWR = 3'h6, CYC_PASSIVE = 3'h7
  } bcs_cycle_t;

  localparam logic [19:0] UPPER_BASE_RST = 20'hF0000;
  localparam logic [19:0] UPPER_LAST_RST = 20'hFFFFF;
  localparam logic [19:0] UPPER_MAX_SIZE = 20'h80000;

  typedef struct packed {
    bcs_cycle_t kind;
    logic dma;
    logic lock;
    logic bhe_n;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bcs_req_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } bcs_status_pins_t;
endpackage

// ==== design/bcs_bus_cycle.sv ====
// Bus cycle sequencer with status, lock, select and write strobe pins.
`timescale 1ns/1ps
module bcs_bus_cycle
  import bcs_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic req_valid,
  input wire bcs_req_t req,
  output logic req_ready,
  output logic done_ff,
  input wire logic hold_req,
  output logic hlda_ff,
  input wire logic srdy,
  input wire logic ardy,
  input wire logic aden_n_strap,
  input wire logic [19:0] upper_base,
  input wire logic [19:0] upper_size,
  input wire logic upper_prog,
  output bcs_status_pins_t status_ff,
  output logic dma_cycle_flag_ff,
  output logic dma_cycle_flag_oe_ff,
  output logic lock_n_ff,
  output logic ucs_n_ff,
  output logic uzi_n_ff,
  output logic normal_pins_ff,
  output logic wr_n_ff,
  output logic wr_n_oe_ff,
  output logic whb_n_ff,
  output logic wlb_n_ff,
  output logic wstrobe_oe_ff,
  output logic [19:0] a_ff,
  output logic [15:0] ad_o_ff,
  output logic ad_oe_ff
);
  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_HOLD} bcs_state_t;
  bcs_state_t state_ff;
  bcs_req_t cur_ff;
  logic rst_seen_ff;
  logic ardy_s1_ff;
  logic ardy_s2_ff;
  logic [19:0] ubase_ff;
  logic [19:0] usize_ff;

  function automatic logic is_write(input bcs_cycle_t k);
    return (k == CYC_MEMWR) || (k == CYC_IOWR);
  endfunction

  function automatic logic in_upper(input logic [19:0] a, input logic [19:0] b, input logic [19:0] s);
    logic [20:0] top;
    top = {1'b0, b} + {1'b0, s};
    return ({1'b0, a} >= {1'b0, b}) && ({1'b0, a} < top);
  endfunction

  function automatic logic is_mem(input bcs_cycle_t k);
    return (k == CYC_FETCH) || (k == CYC_MEMRD) || (k == CYC_MEMWR);
  endfunction

  // Asynchronous ready needs two stages before use
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ardy_s1_ff <= 1'b0;
      ardy_s2_ff <= 1'b0;
    end
    else
    begin
      ardy_s1_ff <= ardy;
      ardy_s2_ff <= ardy_s1_ff;
    end

  logic ready_now;
  assign ready_now = srdy || ardy_s2_ff;
  assign req_ready = (state_ff == ST_IDLE) && !hold_req;

  // Strap caught on the first clock after reset release
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      rst_seen_ff <= 1'b0;
      normal_pins_ff <= 1'b0;
    end
    else if (!rst_seen_ff)
    begin
      rst_seen_ff <= 1'b1;
      normal_pins_ff <= !aden_n_strap;
    end

  // Upper range reprogrammed only between cycles; a write with size above the cap is ignored whole
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ubase_ff <= UPPER_BASE_RST;
      usize_ff <= UPPER_LAST_RST - UPPER_BASE_RST + 20'h00001;
    end
    else if (upper_prog && state_ff == ST_IDLE && upper_size <= UPPER_MAX_SIZE)
    begin
      ubase_ff <= upper_base;
      usize_ff <= upper_size;
    end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      done_ff <= 1'b0;
      hlda_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (hold_req)
          begin
            state_ff <= ST_HOLD;
            hlda_ff <= 1'b1;
          end
          else if (req_valid)
          begin
            cur_ff <= req;
            state_ff <= ST_T1;
          end
        ST_T1: state_ff <= ST_T2;
        ST_T2: state_ff <= ST_T3;
        ST_T3:
          if (ready_now)
            state_ff <= ST_T4;
        ST_T4:
        begin
          state_ff <= ST_IDLE;
          done_ff <= 1'b1;
        end
        ST_HOLD:
          if (!hold_req)
          begin
            state_ff <= ST_IDLE;
            hlda_ff <= 1'b0;
          end
      endcase
    end

  // Pins float only once the bus is really handed over, never mid-cycle
  logic to_hold;
  logic nxt_t1;
  assign to_hold = (state_ff == ST_HOLD) || (state_ff == ST_IDLE && hold_req);
  assign nxt_t1 = (state_ff == ST_IDLE) && !hold_req && req_valid;

  // Status pins: code presented from T1 through T3, passive in T4 and idle
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      status_ff <= '{o: 3'h7, oe: 3'h7};
    else if (to_hold)
      status_ff <= '{o: 3'h7, oe: 3'h0};
    else if (nxt_t1)
      status_ff <= '{o: req.kind, oe: 3'h7};
    else if (state_ff == ST_T3 && ready_now || state_ff == ST_T4 || state_ff == ST_IDLE)
      status_ff <= '{o: CYC_PASSIVE, oe: 3'h7};

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      dma_cycle_flag_ff <= 1'b0;
      dma_cycle_flag_oe_ff <= 1'b0;
      lock_n_ff <= 1'b1;
    end
    else
    begin
      dma_cycle_flag_oe_ff <= normal_pins_ff && !to_hold;
      dma_cycle_flag_ff <= (state_ff == ST_T1 || state_ff == ST_T2 || state_ff == ST_T3) && cur_ff.dma;
      lock_n_ff <= !(nxt_t1 && req.lock);
    end

  // Upper-zero and select latched at T1, held to cycle end
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      uzi_n_ff <= 1'b1;
      ucs_n_ff <= 1'b1;
    end
    else if (to_hold)
    begin
      uzi_n_ff <= 1'b1;
      ucs_n_ff <= 1'b1;
    end
    else if (nxt_t1)
    begin
      uzi_n_ff <= !(normal_pins_ff && (req.addr[19:16] == 4'h0));
      ucs_n_ff <= !(is_mem(req.kind) && in_upper(req.addr, ubase_ff, usize_ff));
    end
    else if (state_ff == ST_T4)
    begin
      uzi_n_ff <= 1'b1;
      ucs_n_ff <= 1'b1;
    end

  // Address pins: mux lines carry address in T1 only, data after
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      a_ff <= '0;
      ad_o_ff <= '0;
      ad_oe_ff <= 1'b0;
    end
    else if (nxt_t1)
    begin
      a_ff <= req.addr;
      ad_o_ff <= req.addr[15:0];
      ad_oe_ff <= 1'b1;
    end
    else if (state_ff == ST_T1)
    begin
      ad_o_ff <= cur_ff.wdata;
      ad_oe_ff <= is_write(cur_ff.kind);
    end
    else if (state_ff == ST_T4 || state_ff == ST_HOLD)
      ad_oe_ff <= 1'b0;

  // Write strobes; the narrow bus drives its byte strobe from T1 like the address
  logic wr_phase;
  assign wr_phase = is_write(cur_ff.kind) && (state_ff == ST_T1 || state_ff == ST_T2)
                    || (state_ff == ST_T3 && is_write(cur_ff.kind) && !ready_now);
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      wr_n_ff <= 1'b1;
      wr_n_oe_ff <= 1'b0;
      whb_n_ff <= 1'b1;
      wlb_n_ff <= 1'b1;
      wstrobe_oe_ff <= 1'b0;
    end
    else
    begin
      wr_n_ff <= !(wr_phase && state_ff != ST_T1);
      wr_n_oe_ff <= !to_hold;
      wstrobe_oe_ff <= 1'b1;
      if (WIDE_BUS)
      begin
        whb_n_ff <= cur_ff.bhe_n || !(wr_phase && state_ff != ST_T1);
        wlb_n_ff <= cur_ff.addr[0] || !(wr_phase && state_ff != ST_T1);
      end
      else
      begin
        whb_n_ff <= 1'b1;
        wlb_n_ff <= !(nxt_t1 && is_write(req.kind) || wr_phase);
      end
    end

  a_status_passive: assert property (@(posedge clock) disable iff (!rstn)
    (state_ff == ST_IDLE && !hold_req && !req_valid) |=> status_ff.o == CYC_PASSIVE)
    else $error("status not passive when idle");
  a_status_code: assert property (@(posedge clock) disable iff (!rstn)
    nxt_t1 |=> status_ff.o == $past(req.kind) && status_ff.oe == 3'h7)
    else $error("status code wrong at T1");
  a_status_float: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_HOLD |=> status_ff.oe == 3'h0)
    else $error("status driven during hold");
  a_dma_flag: assert property (@(posedge clock) disable iff (!rstn)
    (state_ff == ST_T2 && cur_ff.dma) |=> dma_cycle_flag_ff)
    else $error("dma flag missing in T3");
  a_dma_last: assert property (@(posedge clock) disable iff (!rstn)
    (state_ff == ST_T4 && cur_ff.dma) |-> dma_cycle_flag_ff)
    else $error("dma flag missing in T4");
  a_wb_early: assert property (@(posedge clock) disable iff (!rstn)
    (!WIDE_BUS && nxt_t1 && is_write(req.kind)) |=> !wlb_n_ff)
    else $error("byte strobe late on narrow bus");
  a_dma_float: assert property (@(posedge clock) disable iff (!rstn)
    hlda_ff |=> !dma_cycle_flag_oe_ff)
    else $error("dma flag driven in hold");
  a_lock_first: assert property (@(posedge clock) disable iff (!rstn)
    !lock_n_ff |-> state_ff == ST_T1 ##1 lock_n_ff)
    else $error("lock outside first phase");
  a_ucs_hold: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_HOLD |-> ucs_n_ff)
    else $error("upper select active in hold");
  a_uzi_stable: assert property (@(posedge clock) disable iff (!rstn)
    (state_ff == ST_T2 || state_ff == ST_T3) |-> $stable(uzi_n_ff))
    else $error("upper-zero changed mid cycle");
  a_uzi_value: assert property (@(posedge clock) disable iff (!rstn)
    (nxt_t1 && normal_pins_ff) |=> uzi_n_ff == ($past(req.addr[19:16]) != 4'h0))
    else $error("upper-zero value wrong");
  a_whb_or: assert property (@(posedge clock) disable iff (!rstn)
    (WIDE_BUS && !whb_n_ff) |-> !cur_ff.bhe_n && !wr_n_ff)
    else $error("high lane strobe without enable");
  a_wlb_or: assert property (@(posedge clock) disable iff (!rstn)
    (WIDE_BUS && !wlb_n_ff) |-> !cur_ff.addr[0] && !wr_n_ff)
    else $error("low lane strobe without a0 low");
  a_wr_float: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_HOLD |-> !wr_n_oe_ff)
    else $error("write strobe driven in hold");
  a_ad_addr: assert property (@(posedge clock) disable iff (!rstn)
    nxt_t1 |=> ad_o_ff == $past(req.addr[15:0]) ##1 a_ff == $past(a_ff))
    else $error("address phase wrong");
endmodule

// ==== dv/bcs_mem_model.sv ====
// Far-side memory model that ends bus cycles through synchronous ready, or through asynchronous ready in slow mode.
`timescale 1ns/1ps
module bcs_mem_model
  import bcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire bcs_status_pins_t status_ff,
  input wire logic [1:0] waits,
  input wire logic slow,
  output logic srdy,
  output logic ardy
);
  logic [2:0] cnt_ff;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cnt_ff <= 3'h0;
    else if (status_ff.o == 3'h7)
      cnt_ff <= 3'h0;
    else if (cnt_ff != 3'h7)
      cnt_ff <= cnt_ff + 3'h1;
  end
  // Ready comes already synchronised; waits of 2 or 3 stretch T3
  assign srdy = !slow && (cnt_ff > {1'b0, waits});
  // Slow mode answers on the unsynchronised ready instead, srdy held low
  assign ardy = slow && (cnt_ff > {1'b0, waits});
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the bus cycle status and strobe block.
`timescale 1ns/1ps
module testbench;
  import bcs_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic lock_n, uzi_n, ucs_n, dma, whb_n, wlb_n, wr_n, narrow_wr_n;
  } bcs_note_t;
  logic clock = 0, rstn = 0, req_valid = 0, hold_req = 0, upper_prog = 0;
  logic slow = 0, strap = 0, t3 = 0, narrow_wlb_n;
  logic req_ready, done_ff, hlda_ff, srdy, ardy, dma_f, dma_oe, lock_n, ucs_n, uzi_n;
  logic normal_pins, wr_n, wr_oe, whb_n, wlb_n, ws_oe, ad_oe, t2 = 0, prevp = 1;
  logic [19:0] ub = 20'hF0000, us = 20'h10000, a;
  logic [15:0] ad;
  logic [1:0] waits = 2'h0;
  bcs_req_t req = '0;
  bcs_status_pins_t status;
  bcs_note_t notes[$];
  bcs_note_t seen;
  int fail_count = 0, tests_run = 0, cycles = 0, seed_v;
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  bcs_bus_cycle dut_u (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done_ff(done_ff), .hold_req(hold_req), .hlda_ff(hlda_ff),
    .srdy(srdy), .ardy(ardy), .aden_n_strap(strap), .upper_base(ub), .upper_size(us),
    .upper_prog(upper_prog), .status_ff(status), .dma_cycle_flag_ff(dma_f),
    .dma_cycle_flag_oe_ff(dma_oe), .lock_n_ff(lock_n), .ucs_n_ff(ucs_n), .uzi_n_ff(uzi_n),
    .normal_pins_ff(normal_pins), .wr_n_ff(wr_n), .wr_n_oe_ff(wr_oe), .whb_n_ff(whb_n),
    .wlb_n_ff(wlb_n), .wstrobe_oe_ff(ws_oe), .a_ff(a), .ad_o_ff(ad), .ad_oe_ff(ad_oe));
  bcs_bus_cycle #(.WIDE_BUS(1'b0)) dut8_u (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(), .done_ff(), .hold_req(hold_req), .hlda_ff(), .srdy(srdy), .ardy(ardy),
    .aden_n_strap(strap), .upper_base(ub), .upper_size(us), .upper_prog(upper_prog), .status_ff(),
    .dma_cycle_flag_ff(), .dma_cycle_flag_oe_ff(), .lock_n_ff(), .ucs_n_ff(), .uzi_n_ff(),
    .normal_pins_ff(), .wr_n_ff(), .wr_n_oe_ff(), .whb_n_ff(), .wlb_n_ff(narrow_wlb_n),
    .wstrobe_oe_ff(), .a_ff(), .ad_o_ff(), .ad_oe_ff());
  bcs_mem_model mem_u (.clock(clock), .rstn(rstn), .status_ff(status), .waits(waits),
    .slow(slow), .srdy(srdy), .ardy(ardy));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One whole bus cycle; expectation noted before the request goes out
  task automatic issue(logic [19:0] ar, int k);
    bcs_req_t r;
    bcs_note_t n;
    logic w, m, s;
    logic [1:0] wv;
    int t;
    r = '{bcs_cycle_t'(k), 1'($urandom), 1'($urandom), 1'($urandom), ar, 16'($urandom)};
    w = k == 2 || k == 6;
    m = k > 3;
    s = 1'($urandom);
    wv = 2'($urandom);
    n = '{k[2:0], !r.lock, strap || ar[19:16] != 4'h0, !(m && ar >= ub && ar - ub < us), r.dma,
      r.bhe_n | !w, ar[0] | !w, !w, !w};
    notes.push_back(n);
    waits <= wv;
    slow <= s;
    req <= r;
    req_valid <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clock);
      t++;
    end while (req_ready !== 1'b1 && t < 50);
    req_valid <= 1'b0;
    if (t >= 50) check("taken", 1, 0);
    t = 0;
    do
    begin
      @(posedge clock);
      t++;
    end while (done_ff !== 1'b1 && t < 60);
    if (done_ff !== 1'b1) check("done", 1, 0);
    // Slow ready pays two synchroniser stages on top of the waits
    else check("cycles", s ? 16'(wv) + 16'h6 : (wv > 2'h1 ? 16'(wv) + 16'h4 : 16'h5), 16'(t));
  endtask
  // Captures T1 fields, then T2 fields, and compares against the oldest note
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
    // Lane strobes go low only from T3, so they are taken a cycle after T2
    if (t3)
    begin
      seen.whb_n = whb_n;
      seen.wlb_n = wlb_n;
      seen.wr_n = wr_n;
      if (notes.size() == 0) check("note", 0, 1);
      else check("cycle", notes.pop_front(), seen);
    end
    t3 = t2;
    if (t2)
    begin
      seen.dma = dma_f;
      check("uzi_hold", seen.uzi_n, uzi_n);
      check("lock_t2", 1, lock_n);
    end
    t2 = rstn && prevp && status.oe === 3'h7 && status.o !== 3'h7;
    if (t2)
    begin
      seen.kind = status.o;
      seen.lock_n = lock_n;
      seen.uzi_n = uzi_n;
      seen.ucs_n = ucs_n;
      seen.narrow_wr_n = narrow_wlb_n;
    end
    prevp = status.o === 3'h7;
    if (done_ff === 1'b1) check("passive", 7, status.o);
  end
  initial
  begin
    seed_v = $urandom(31209);
    @(posedge clock);
    #1;
    check("rst_dma_oe", 0, dma_oe);
    check("rst_wr_oe", 0, wr_oe);
    check("rst_lane_oe", 0, ws_oe);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("normal_pins", 1, normal_pins);
    @(posedge clock);
    check("dma_oe_normal", 1, dma_oe);
    for (int i = 0; i < 21; i++)
      issue(i[0] ? {4'hF, 16'($urandom)} : {4'(i / 4), 16'($urandom)}, i % 7);
    ub <= 20'h40000;
    us <= 20'h20000;
    upper_prog <= 1'b1;
    @(posedge clock);
    upper_prog <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 12; i++)
      issue({3'h2, 17'($urandom)} ^ {i[0], 19'h0}, 4 + i % 3);
    hold_req <= 1'b1;
    for (int t = 0; t < 20 && hlda_ff !== 1'b1; t++) @(posedge clock);
    #1;
    check("hold_status_oe", 0, status.oe);
    check("hold_ucs", 1, ucs_n);
    check("hold_wr_oe", 0, wr_oe);
    check("hold_dma_oe", 0, dma_oe);
    @(posedge clock);
    hold_req <= 1'b0;
    for (int t = 0; t < 20 && hlda_ff !== 1'b0; t++) @(posedge clock);
    issue(20'h40002, 6);
    // Second reset with the strap high: pins stay general purpose, range back to default
    rstn <= 1'b0;
    strap <= 1'b1;
    ub <= 20'hF0000;
    us <= 20'h10000;
    @(posedge clock);
    #1;
    check("mid_rst_lane_oe", 0, ws_oe);
    check("mid_rst_dma_oe", 0, dma_oe);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("strap_high", 0, normal_pins);
    @(posedge clock);
    check("dma_oe_pio", 0, dma_oe);
    for (int i = 0; i < 6; i++)
      issue({i[0] ? 4'hF : 4'h0, 16'($urandom)}, 4 + i % 3);
    repeat (3) @(posedge clock);
    tally_and_finish();
  end
endmodule
